/* File: fcwp_device.sv */
// Flash status and setup registers with write-protect logic, device end of the link
// Operation
// - Three-bit drive field, all ones, write-only-by-command
// - Decode six drive levels, two codes reserved
// - Origin bit three, zero means top region
// - Origin bit once set never clears
// - Wide-address bit set/cleared by its commands
// - Fast read dummy clocks 8,6,8,10
// - Dual-IO 4,6,8,10; quad-IO 6,4,8,10
// - Register write needs unlock latch first
// - Write sets lock, quad, level; not busy/unlock
// - Register write only at 8 or 16 bits
// - Busy from chip-select rise, then clear busy, unlock
// - Status readable during write cycle
// - Lock clear or pin high: writes accepted
// - Lock set and pin low: writes rejected
// - Hard lock entered once both conditions hold, in either order
// - Pin high leaves hard lock
// - Four-wire mode or quad disables hard lock
// - Refuse program/erase into protected region
// - Host holds pin high during locked write
// - Status byte layout lock,quad,level,unlock,busy
//
// The implementer's own choices: register access over AXI4-Lite and the register offsets.
`timescale 1ns/10ps
`include "fcwp_params.svh"
module fcwp_device #(
	parameter int REG_WRITE_CYCLES = `FCWP_REG_WRITE_TIME_NS * `FCWP_CLK_MHZ / 1000
) (
	input wire logic clk,
	input wire logic resetn,
	fcwp_link_if.dev link,
	input wire logic four_wire_command_mode,
	input wire logic pe_req,
	input wire logic [9:0] pe_block,
	output logic [7:0] status_byte_reg,
	output logic [7:0] device_setup_register_reg,
	output logic hard_lock_mode_reg,
	output logic soft_lock_mode_reg,
	output logic [3:0] dummy_fast_reg,
	output logic [3:0] dummy_dual_io_reg,
	output logic [3:0] dummy_quad_io_reg,
	output logic [7:0] drive_ohms_reg,
	output logic pe_refused_reg,
	output logic pe_granted_reg
);
	// ==========================================================
	// Functions
	// Picks the dummy clock count of a code from a packed table
	function automatic logic [3:0] dummy_pick(input logic [15:0] tbl, input logic [1:0] dc);
		return tbl[{dc, 2'b00} +: 4];
	endfunction

	// Impedance in ohms of a drive code, zero for reserved codes
	function automatic logic [7:0] drive_pick(input logic [2:0] code);
		logic [63:0] tbl;
		tbl = `FCWP_DRIVE_TABLE;
		return tbl[{code, 3'b000} +: 8];
	endfunction

	// True when a block lies in the region set by level and origin
	function automatic logic in_region(input logic [3:0] lvl, input logic low_end, input logic [9:0] blk);
		logic [10:0] n;
		n = (lvl == 4'h0) ? 11'h000 : (lvl > 4'ha) ? `FCWP_BLOCK_COUNT : 11'(11'h001 << (lvl - 4'h1));
		return low_end ? ({1'b0, blk} < n) : ({1'b0, blk} >= (`FCWP_BLOCK_COUNT - n));
	endfunction

	// ==========================================================
	// Pin synchronisers
	logic cs_s1, cs_s2, cs_d;
	logic sck_s1, sck_s2, sck_d;
	logic mosi_s1, mosi_s2;
	logic wp_s1, wp_s2;

	// Two flops on every pin, a third stage on chip select and serial clock for edge finding
	always_ff @(posedge clk) begin
		if (!resetn) begin
			cs_s1 <= 1'b1;
			cs_s2 <= 1'b1;
			cs_d <= 1'b1;
			sck_s1 <= 1'b0;
			sck_s2 <= 1'b0;
			sck_d <= 1'b0;
			mosi_s1 <= 1'b0;
			mosi_s2 <= 1'b0;
			wp_s1 <= 1'b1;
			wp_s2 <= 1'b1;
		end else begin
			cs_s1 <= link.cs_n;
			cs_s2 <= cs_s1;
			cs_d <= cs_s2;
			sck_s1 <= link.sclk;
			sck_s2 <= sck_s1;
			sck_d <= sck_s2;
			mosi_s1 <= link.mosi;
			mosi_s2 <= mosi_s1;
			wp_s1 <= link.io_line_two_n;
			wp_s2 <= wp_s1;
		end
	end

	logic sck_rise, sck_fall, frame_start, frame_end;
	assign sck_rise = sck_s2 & ~sck_d & ~cs_s2;
	assign sck_fall = ~sck_s2 & sck_d & ~cs_s2;
	assign frame_start = ~cs_s2 & cs_d;
	assign frame_end = cs_s2 & ~cs_d;

	// ==========================================================
	// Frame capture
	logic [5:0] bit_cnt_reg;
	logic [7:0] op_reg;
	logic [15:0] shift_reg;

	// Counts serial clocks, first eight form the opcode, the rest shift data
	always_ff @(posedge clk) begin
		if (!resetn) begin
			bit_cnt_reg <= 6'h00;
			op_reg <= 8'h00;
			shift_reg <= 16'h0000;
		end else if (frame_start) begin
			bit_cnt_reg <= 6'h00;
			op_reg <= 8'h00;
			shift_reg <= 16'h0000;
		end else if (sck_rise) begin
			if (bit_cnt_reg != `FCWP_BITS_MAX) begin
				bit_cnt_reg <= bit_cnt_reg + 6'h01;
			end
			if (bit_cnt_reg < `FCWP_BITS_OPCODE) begin
				op_reg <= {op_reg[6:0], mosi_s2};
			end else begin
				shift_reg <= {shift_reg[14:0], mosi_s2};
			end
		end
	end

	// ==========================================================
	// Command decode
	logic busy, hard_lock_now, short_write, long_write, write_ok, simple_cmd;
	logic [15:0] wait_cnt_reg;
	logic [7:0] pend_status_reg;
	logic [7:0] pend_setup_reg;
	logic pend_two_reg;

	assign busy = status_byte_reg[`FCWP_ST_BUSY];
	// Lock bit with pin low, unless the pin is a data line
	assign hard_lock_now = status_byte_reg[`FCWP_ST_LOCK] & ~wp_s2
		& ~status_byte_reg[`FCWP_ST_QUAD] & ~four_wire_command_mode;
	assign short_write = bit_cnt_reg == `FCWP_BITS_ONE_BYTE;
	assign long_write = bit_cnt_reg == `FCWP_BITS_TWO_BYTES;
	assign simple_cmd = frame_end & ~busy & (bit_cnt_reg == `FCWP_BITS_OPCODE);
	// Accepted only at a byte boundary, with the latch set and no hard lock
	assign write_ok = frame_end & (op_reg == `FCWP_OP_WRITE_REGS) & (short_write | long_write)
		& status_byte_reg[`FCWP_ST_UNLOCK] & ~busy
		& ~hard_lock_now;

	// ==========================================================
	// Status byte, setup byte and self-timed write cycle
	always_ff @(posedge clk) begin
		if (!resetn) begin
			status_byte_reg <= `FCWP_STATUS_RESET;
			device_setup_register_reg <= `FCWP_SETUP_RESET;
			wait_cnt_reg <= 16'h0000;
			pend_status_reg <= 8'h00;
			pend_setup_reg <= 8'h00;
			pend_two_reg <= 1'b0;
		end else if (write_ok) begin
			// Cycle starts at the chip-select rise
			status_byte_reg[`FCWP_ST_BUSY] <= 1'b1;
			wait_cnt_reg <= 16'(REG_WRITE_CYCLES - 1);
			pend_status_reg <= long_write ? shift_reg[15:8] : shift_reg[7:0];
			pend_setup_reg <= shift_reg[7:0];
			pend_two_reg <= long_write;
		end else if (busy) begin
			if (wait_cnt_reg == 16'h0000) begin
				// End of cycle: commit pending bytes, drop busy and latch
				status_byte_reg[`FCWP_ST_LOCK:`FCWP_ST_LEVEL_LO] <=
					pend_status_reg[`FCWP_ST_LOCK:`FCWP_ST_LEVEL_LO];
				status_byte_reg[`FCWP_ST_BUSY] <= 1'b0;
				status_byte_reg[`FCWP_ST_UNLOCK] <= 1'b0;
				if (pend_two_reg) begin
					device_setup_register_reg[`FCWP_CFG_DC_HI:`FCWP_CFG_DC_LO] <=
						pend_setup_reg[`FCWP_CFG_DC_HI:`FCWP_CFG_DC_LO];
					device_setup_register_reg[`FCWP_CFG_ORIGIN] <= device_setup_register_reg[`FCWP_CFG_ORIGIN]
						| pend_setup_reg[`FCWP_CFG_ORIGIN];
					device_setup_register_reg[`FCWP_CFG_DRIVE_HI:`FCWP_CFG_DRIVE_LO] <=
						pend_setup_reg[`FCWP_CFG_DRIVE_HI:`FCWP_CFG_DRIVE_LO];
				end
			end else begin
				wait_cnt_reg <= wait_cnt_reg - 16'h0001;
			end
		end else if (simple_cmd) begin
			// One-byte commands take effect at the chip-select rise
			case (op_reg)
				`FCWP_OP_WRITE_UNLOCK: status_byte_reg[`FCWP_ST_UNLOCK] <= 1'b1;
				`FCWP_OP_ENTER_WIDE: device_setup_register_reg[`FCWP_CFG_WIDE] <= 1'b1;
				`FCWP_OP_EXIT_WIDE: device_setup_register_reg[`FCWP_CFG_WIDE] <= 1'b0;
				default: ;
			endcase
		end
	end

	// ==========================================================
	// Serial read-back, served even while busy
	always_ff @(posedge clk) begin
		if (!resetn) begin
			link.miso <= 1'b0;
		end else if (sck_fall && bit_cnt_reg >= `FCWP_BITS_OPCODE) begin
			case (op_reg)
				`FCWP_OP_READ_STATUS: link.miso <= status_byte_reg[3'h7 - bit_cnt_reg[2:0]];
				`FCWP_OP_READ_SETUP: link.miso <= device_setup_register_reg[3'h7 - bit_cnt_reg[2:0]];
				default: link.miso <= 1'b0;
			endcase
		end else if (frame_start) begin
			link.miso <= 1'b0;
		end
	end

	// ==========================================================
	// Lock mode indicators
	always_ff @(posedge clk) begin
		if (!resetn) begin
			hard_lock_mode_reg <= 1'b0;
			soft_lock_mode_reg <= 1'b1;
		end else begin
			hard_lock_mode_reg <= hard_lock_now;
			soft_lock_mode_reg <= ~hard_lock_now;
		end
	end

	// ==========================================================
	// Decoded setup fields
	always_ff @(posedge clk) begin
		if (!resetn) begin
			dummy_fast_reg <= 4'h0;
			dummy_dual_io_reg <= 4'h0;
			dummy_quad_io_reg <= 4'h0;
			drive_ohms_reg <= 8'h00;
		end else begin
			dummy_fast_reg <= dummy_pick(`FCWP_DUMMY_FAST,
				device_setup_register_reg[`FCWP_CFG_DC_HI:`FCWP_CFG_DC_LO]);
			dummy_dual_io_reg <= dummy_pick(`FCWP_DUMMY_DUAL_IO,
				device_setup_register_reg[`FCWP_CFG_DC_HI:`FCWP_CFG_DC_LO]);
			dummy_quad_io_reg <= dummy_pick(`FCWP_DUMMY_QUAD_IO,
				device_setup_register_reg[`FCWP_CFG_DC_HI:`FCWP_CFG_DC_LO]);
			drive_ohms_reg <= drive_pick(device_setup_register_reg[`FCWP_CFG_DRIVE_HI:`FCWP_CFG_DRIVE_LO]);
		end
	end

	// ==========================================================
	// Program and erase gate, same in both lock modes
	always_ff @(posedge clk) begin
		if (!resetn) begin
			pe_refused_reg <= 1'b0;
			pe_granted_reg <= 1'b0;
		end else begin
			pe_refused_reg <= pe_req & in_region(status_byte_reg[`FCWP_ST_LEVEL_HI:`FCWP_ST_LEVEL_LO],
				device_setup_register_reg[`FCWP_CFG_ORIGIN], pe_block);
			pe_granted_reg <= pe_req & ~in_region(status_byte_reg[`FCWP_ST_LEVEL_HI:`FCWP_ST_LEVEL_LO],
				device_setup_register_reg[`FCWP_CFG_ORIGIN], pe_block);
		end
	end
endmodule

/* File: fcwp_params.svh */
// Constants of the flash setup and write-protect link: opcodes, bit positions, tables, timing
`ifndef FCWP_PARAMS_SVH
`define FCWP_PARAMS_SVH
// Clock and timing
`define FCWP_CLK_MHZ 200
`define FCWP_REG_WRITE_TIME_NS 40000
`define FCWP_SCLK_HALF 8'h0c
// Opcodes
`define FCWP_OP_WRITE_UNLOCK 8'h06
`define FCWP_OP_WRITE_REGS 8'h01
`define FCWP_OP_READ_STATUS 8'h05
`define FCWP_OP_READ_SETUP 8'h15
`define FCWP_OP_ENTER_WIDE 8'hb7
`define FCWP_OP_EXIT_WIDE 8'he9
// Frame lengths in serial clocks
`define FCWP_BITS_OPCODE 6'h08
`define FCWP_BITS_ONE_BYTE 6'h10
`define FCWP_BITS_TWO_BYTES 6'h18
`define FCWP_BITS_MAX 6'h3f
// Status byte fields
`define FCWP_ST_LOCK 7
`define FCWP_ST_QUAD 6
`define FCWP_ST_LEVEL_HI 5
`define FCWP_ST_LEVEL_LO 2
`define FCWP_ST_UNLOCK 1
`define FCWP_ST_BUSY 0
`define FCWP_STATUS_RESET 8'h00
// Setup byte fields
`define FCWP_CFG_DC_HI 7
`define FCWP_CFG_DC_LO 6
`define FCWP_CFG_WIDE 5
`define FCWP_CFG_ORIGIN 3
`define FCWP_CFG_DRIVE_HI 2
`define FCWP_CFG_DRIVE_LO 0
`define FCWP_SETUP_RESET 8'h07
// Dummy clock tables, one nibble per code, code 11 in the top nibble
`define FCWP_DUMMY_FAST 16'ha868
`define FCWP_DUMMY_DUAL_IO 16'ha864
`define FCWP_DUMMY_QUAD_IO 16'ha846
// Drive impedance in ohms per code, code 7 in the top byte, 0 means reserved
`define FCWP_DRIVE_TABLE 64'h1e0f_1400_2d3c_5a00
// Array size in protectable blocks
`define FCWP_BLOCK_COUNT 11'h400
// Controller register offsets and bus answers
`define FCWP_ADDR_CMD 8'h00
`define FCWP_ADDR_TX 8'h04
`define FCWP_ADDR_RX 8'h08
`define FCWP_ADDR_STAT 8'h0c
`define FCWP_ADDR_PIN 8'h10
`define FCWP_RESP_OKAY 2'h0
`define FCWP_RESP_SLVERR 2'h2
`endif

/* File: fcwp_pkg.sv */
// Types of the controller end of the flash setup and write-protect link
package fcwp_pkg;
	typedef enum logic [2:0] {
		FCWP_IDLE,
		FCWP_SETUP,
		FCWP_LOW,
		FCWP_HIGH,
		FCWP_HOLD,
		FCWP_GAP
	} fcwp_host_state_t;
endpackage

/* File: fcwp_link_if.sv */
// Serial link between the flash controller and the flash setup logic
`timescale 1ns/10ps
interface fcwp_link_if;
	logic cs_n;
	logic sclk;
	logic mosi;
	logic miso;
	logic io_line_two_n;
	modport dev (
		input cs_n,
		input sclk,
		input mosi,
		input io_line_two_n,
		output miso
	);
	modport host (
		output cs_n,
		output sclk,
		output mosi,
		output io_line_two_n,
		input miso
	);
endinterface

/* File: fcwp_host.sv */
// Serial flash controller end, ordered by software over AXI4-Lite
`timescale 1ns/10ps
`include "fcwp_params.svh"
module fcwp_host (
	input wire logic clk,
	input wire logic resetn,
	input wire logic [7:0] s_axi_awaddr,
	input wire logic s_axi_awvalid,
	output logic s_axi_awready,
	input wire logic [31:0] s_axi_wdata,
	input wire logic [3:0] s_axi_wstrb,
	input wire logic s_axi_wvalid,
	output logic s_axi_wready,
	output logic [1:0] s_axi_bresp,
	output logic s_axi_bvalid,
	input wire logic s_axi_bready,
	input wire logic [7:0] s_axi_araddr,
	input wire logic s_axi_arvalid,
	output logic s_axi_arready,
	output logic [31:0] s_axi_rdata,
	output logic [1:0] s_axi_rresp,
	output logic s_axi_rvalid,
	input wire logic s_axi_rready,
	fcwp_link_if.host link
);
	// ==========================================================
	// Functions
	// Merges a written word into a register under byte strobes
	function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] nw, input logic [3:0] strb);
		logic [31:0] r;
		r = old;
		for (int i = 0; i < 4; i++) begin
			if (strb[i]) begin
				r[8 * i +: 8] = nw[8 * i +: 8];
			end
		end
		return r;
	endfunction

	fcwp_pkg::fcwp_host_state_t state_reg;
	logic [7:0] aw_addr_reg;
	logic [31:0] w_data_reg;
	logic [3:0] w_strb_reg;
	logic [31:0] tx_reg;
	logic [12:0] cmd_reg;
	logic launch_reg;
	logic [15:0] rx_reg;
	logic idle;
	assign idle = state_reg == fcwp_pkg::FCWP_IDLE;

	// ==========================================================
	// Write channels: address and data in either order, then response
	always_ff @(posedge clk) begin
		if (!resetn) begin
			s_axi_awready <= 1'b1;
			s_axi_wready <= 1'b1;
			s_axi_bvalid <= 1'b0;
			s_axi_bresp <= `FCWP_RESP_OKAY;
			aw_addr_reg <= 8'h00;
			w_data_reg <= 32'h0000_0000;
			w_strb_reg <= 4'h0;
			tx_reg <= 32'h0000_0000;
			cmd_reg <= 13'h0000;
			launch_reg <= 1'b0;
			link.io_line_two_n <= 1'b1;
		end else begin
			launch_reg <= 1'b0;
			if (s_axi_awvalid && s_axi_awready) begin
				aw_addr_reg <= s_axi_awaddr;
				s_axi_awready <= 1'b0;
			end
			if (s_axi_wvalid && s_axi_wready) begin
				w_data_reg <= s_axi_wdata;
				w_strb_reg <= s_axi_wstrb;
				s_axi_wready <= 1'b0;
			end
			if (!s_axi_awready && !s_axi_wready && !s_axi_bvalid) begin
				s_axi_bvalid <= 1'b1;
				s_axi_bresp <= `FCWP_RESP_OKAY;
				case (aw_addr_reg)
					`FCWP_ADDR_CMD: begin
						// A new frame is ignored while one is running
						if (idle && (&w_strb_reg[1:0])) begin
							cmd_reg <= w_data_reg[12:0];
							launch_reg <= 1'b1;
						end
					end
					`FCWP_ADDR_TX: tx_reg <= merge(tx_reg, w_data_reg, w_strb_reg);
					`FCWP_ADDR_PIN: begin
						if (w_strb_reg[0]) begin
							link.io_line_two_n <= w_data_reg[0];
						end
					end
					`FCWP_ADDR_RX, `FCWP_ADDR_STAT: ;
					default: s_axi_bresp <= `FCWP_RESP_SLVERR;
				endcase
			end
			if (s_axi_bvalid && s_axi_bready) begin
				s_axi_bvalid <= 1'b0;
				s_axi_awready <= 1'b1;
				s_axi_wready <= 1'b1;
			end
		end
	end

	// ==========================================================
	// Read channel: one cycle from address to data
	always_ff @(posedge clk) begin
		if (!resetn) begin
			s_axi_arready <= 1'b1;
			s_axi_rvalid <= 1'b0;
			s_axi_rdata <= 32'h0000_0000;
			s_axi_rresp <= `FCWP_RESP_OKAY;
		end else if (s_axi_arvalid && s_axi_arready) begin
			s_axi_arready <= 1'b0;
			s_axi_rvalid <= 1'b1;
			s_axi_rresp <= `FCWP_RESP_OKAY;
			case (s_axi_araddr)
				`FCWP_ADDR_CMD: s_axi_rdata <= {19'h00000, cmd_reg};
				`FCWP_ADDR_TX: s_axi_rdata <= tx_reg;
				`FCWP_ADDR_RX: s_axi_rdata <= {16'h0000, rx_reg};
				`FCWP_ADDR_STAT: s_axi_rdata <= {31'h0000_0000, ~idle};
				`FCWP_ADDR_PIN: s_axi_rdata <= {31'h0000_0000, link.io_line_two_n};
				default: begin
					s_axi_rdata <= 32'h0000_0000;
					s_axi_rresp <= `FCWP_RESP_SLVERR;
				end
			endcase
		end else if (s_axi_rvalid && s_axi_rready) begin
			s_axi_rvalid <= 1'b0;
			s_axi_arready <= 1'b1;
		end
	end

	// ==========================================================
	// Serial engine: opcode then up to 31 data bits, clock divided from clk
	logic miso_s1, miso_s2;
	logic [7:0] div_reg;
	logic [5:0] bits_left_reg;
	logic [39:0] out_sh_reg;
	logic tick;
	assign tick = div_reg == 8'h00;

	// Two flops on the returning data pin
	always_ff @(posedge clk) begin
		if (!resetn) begin
			miso_s1 <= 1'b0;
			miso_s2 <= 1'b0;
		end else begin
			miso_s1 <= link.miso;
			miso_s2 <= miso_s1;
		end
	end

	always_ff @(posedge clk) begin
		if (!resetn) begin
			state_reg <= fcwp_pkg::FCWP_IDLE;
			link.cs_n <= 1'b1;
			link.sclk <= 1'b0;
			link.mosi <= 1'b0;
			div_reg <= 8'h00;
			bits_left_reg <= 6'h00;
			out_sh_reg <= 40'h00_0000_0000;
			rx_reg <= 16'h0000;
		end else begin
			div_reg <= tick ? `FCWP_SCLK_HALF - 8'h01 : div_reg - 8'h01;
			case (state_reg)
				fcwp_pkg::FCWP_IDLE: begin
					if (launch_reg) begin
						link.cs_n <= 1'b0;
						link.mosi <= cmd_reg[7];
						out_sh_reg <= {cmd_reg[6:0], tx_reg[15:0], 17'h00000};
						bits_left_reg <= 6'(`FCWP_BITS_OPCODE + {1'b0, cmd_reg[12:8]});
						div_reg <= `FCWP_SCLK_HALF - 8'h01;
						state_reg <= fcwp_pkg::FCWP_LOW;
					end
				end
				fcwp_pkg::FCWP_LOW: begin
					if (tick) begin
						link.sclk <= 1'b1;
						rx_reg <= {rx_reg[14:0], miso_s2};
						state_reg <= fcwp_pkg::FCWP_HIGH;
					end
				end
				fcwp_pkg::FCWP_HIGH: begin
					if (tick) begin
						link.sclk <= 1'b0;
						link.mosi <= out_sh_reg[39];
						out_sh_reg <= {out_sh_reg[38:0], 1'b0};
						bits_left_reg <= bits_left_reg - 6'h01;
						state_reg <= (bits_left_reg == 6'h01) ? fcwp_pkg::FCWP_HOLD : fcwp_pkg::FCWP_LOW;
					end
				end
				fcwp_pkg::FCWP_HOLD: begin
					if (tick) begin
						link.cs_n <= 1'b1;
						link.mosi <= 1'b0;
						state_reg <= fcwp_pkg::FCWP_GAP;
					end
				end
				fcwp_pkg::FCWP_GAP: begin
					if (tick) begin
						state_reg <= fcwp_pkg::FCWP_IDLE;
					end
				end
				default: state_reg <= fcwp_pkg::FCWP_IDLE;
			endcase
		end
	end
endmodule

/* File: fcwp_link_asserts.sv */
// Framing checks on the serial link between the flash controller and the flash setup logic
`timescale 1ns/10ps
module fcwp_link_asserts (
	input wire logic clk,
	input wire logic resetn,
	input wire logic cs_n,
	input wire logic sclk,
	input wire logic mosi,
	input wire logic miso,
	input wire logic io_line_two_n
);
	logic [7:0] hi_cnt;
	logic [7:0] lo_cnt;
	logic [5:0] rise_cnt;
	logic sclk_reg;
	default clocking cb @(posedge clk);
	endclocking
	default disable iff (!resetn);
	// ==========================================
	// Phase lengths of the serial clock
	always_ff @(posedge clk) begin
		hi_cnt <= (!resetn || !sclk) ? 8'h00 : hi_cnt + 8'h01;
	end
	always_ff @(posedge clk) begin
		lo_cnt <= (!resetn || cs_n || sclk) ? 8'h00 : lo_cnt + 8'h01;
	end
	// Serial clock rises within the current frame
	always_ff @(posedge clk) begin
		sclk_reg <= resetn & sclk;
		rise_cnt <= (!resetn || cs_n) ? 6'h00 : rise_cnt + {5'h00, sclk & !sclk_reg};
	end
	// ==========================================
	// Assertions
	chk_idle_clock_low: assert property (cs_n |-> !sclk)
		else $error("serial clock high outside a frame");
	chk_high_phase_len: assert property ($fell(sclk) |-> hi_cnt == 8'h0c)
		else $error("serial clock high phase is not 12 cycles");
	chk_low_phase_len: assert property ($rose(sclk) |-> lo_cnt == 8'h0c)
		else $error("serial clock low phase is not 12 cycles");
	chk_mosi_held_high: assert property (sclk && $past(sclk) |-> $stable(mosi))
		else $error("data to device changed while clock high");
	chk_miso_held_high: assert property (sclk && $past(sclk) |-> $stable(miso))
		else $error("data from device changed while clock high");
	chk_frame_bit_count: assert property ($rose(cs_n) |-> rise_cnt >= 6'h08 && rise_cnt <= 6'h27)
		else $error("frame length out of range");
	chk_select_gap: assert property ($rose(cs_n) |=> cs_n [*8])
		else $error("select gap after frame too short");
	chk_select_lead: assert property ($fell(cs_n) |-> !sclk [*8])
		else $error("clock rose too soon after select");
	// Main scenarios seen on the wire
	cov_two_byte_write: cover property ($rose(cs_n) && rise_cnt == 6'h18);
	cov_odd_length: cover property ($rose(cs_n) && rise_cnt == 6'h14);
	cov_pin_low_frame: cover property (!cs_n && !io_line_two_n);
endmodule

/* File: test_flash_config_and_write_protect.sv */
// Self-checking bench: controller and flash setup logic joined over the serial link
`timescale 1ns/10ps
`include "fcwp_params.svh"
module test_flash_config_and_write_protect;
	logic clk = 1'b0;
	logic resetn = 1'b0;
	logic [7:0] awaddr = 8'h00;
	logic [7:0] araddr = 8'h00;
	logic [31:0] wdata = 32'h0;
	logic awvalid = 1'b0;
	logic wvalid = 1'b0;
	logic bready = 1'b0;
	logic arvalid = 1'b0;
	logic rready = 1'b0;
	logic four_wire = 1'b0;
	logic pe_req = 1'b0;
	logic [9:0] pe_block = 10'h000;
	logic awready, wready, bvalid, arready, rvalid;
	logic [1:0] bresp, rresp, rsp;
	logic [31:0] rdata, rd_val;
	logic [7:0] status_byte, setup_byte, drive_ohms;
	logic [3:0] dummy_fast, dummy_dual, dummy_quad;
	logic hard_lock, soft_lock, pe_refused, pe_granted;
	logic [2:0] code;
	logic [7:0] ohms_tab [8] = '{8'h00, 8'h5a, 8'h3c, 8'h2d, 8'h00, 8'h14, 8'h0f, 8'h1e};
	logic [3:0] fast_tab [4] = '{4'h8, 4'h6, 4'h8, 4'ha};
	logic [3:0] dual_tab [4] = '{4'h4, 4'h6, 4'h8, 4'ha};
	logic [3:0] quad_tab [4] = '{4'h6, 4'h4, 4'h8, 4'ha};
	int err_total = 0;
	int compares = 0;
	// Clock at 200 MHz
	always #2.5 clk = ~clk;
	fcwp_link_if link();
	fcwp_host fcwp_host_i (.clk(clk), .resetn(resetn), .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid),
		.s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(4'hf), .s_axi_wvalid(wvalid),
		.s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
		.s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready), .s_axi_rdata(rdata),
		.s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready), .link(link));
	// Write cycle long enough to read status while it runs
	fcwp_device #(.REG_WRITE_CYCLES(600)) fcwp_device_i (.clk(clk), .resetn(resetn), .link(link),
		.four_wire_command_mode(four_wire), .pe_req(pe_req), .pe_block(pe_block),
		.status_byte_reg(status_byte), .device_setup_register_reg(setup_byte), .hard_lock_mode_reg(hard_lock),
		.soft_lock_mode_reg(soft_lock), .dummy_fast_reg(dummy_fast), .dummy_dual_io_reg(dummy_dual),
		.dummy_quad_io_reg(dummy_quad), .drive_ohms_reg(drive_ohms), .pe_refused_reg(pe_refused),
		.pe_granted_reg(pe_granted));
	fcwp_link_asserts fcwp_link_asserts_i (.clk(clk), .resetn(resetn), .cs_n(link.cs_n), .sclk(link.sclk),
		.mosi(link.mosi), .miso(link.miso), .io_line_two_n(link.io_line_two_n));
	// ==========================================
	// Reporting
	task automatic close_out();
		$display("Comparisons %0d, mismatches %0d", compares, err_total);
		if (err_total == 0 && compares > 0) begin
			$display("ALL CHECKS OK");
		end else begin
			$display("CHECKS NOT OK");
		end
		$finish;
	endtask
	task automatic check(input logic [39:0] seen, input logic [39:0] exp);
		compares++;
		if (seen !== exp) begin
			err_total++;
			$display("FAIL at %0t: seen %h expected %h", $time, seen, exp);
		end
	endtask
	task automatic timed_out();
		err_total++;
		$display("FAIL at %0t: wait ran out", $time);
		close_out();
	endtask
	// ==========================================
	// Bus and link access
	task automatic axi_wr(input logic [7:0] a, input logic [31:0] d);
		int n;
		@(posedge clk);
		awaddr <= a;
		wdata <= d;
		awvalid <= 1'b1;
		wvalid <= 1'b1;
		bready <= 1'b1;
		for (n = 0; n < 64; n++) begin
			@(posedge clk);
			if (awready) awvalid <= 1'b0;
			if (wready) wvalid <= 1'b0;
			if (bvalid) break;
		end
		rsp = bresp;
		bready <= 1'b0;
		if (n == 64) timed_out();
	endtask
	task automatic axi_rd(input logic [7:0] a);
		int n;
		@(posedge clk);
		araddr <= a;
		arvalid <= 1'b1;
		rready <= 1'b1;
		for (n = 0; n < 64; n++) begin
			@(posedge clk);
			if (arready) arvalid <= 1'b0;
			if (rvalid) break;
		end
		rd_val = rdata;
		rsp = rresp;
		rready <= 1'b0;
		if (n == 64) timed_out();
	endtask
	// One link frame: opcode, then bits data bits from the top of data
	task automatic frame(input logic [7:0] op, input logic [4:0] bits, input logic [15:0] data);
		int n;
		axi_wr(`FCWP_ADDR_TX, {16'h0000, data});
		axi_wr(`FCWP_ADDR_CMD, {19'h00000, bits, op});
		for (n = 0; n < 1000; n++) begin
			axi_rd(`FCWP_ADDR_STAT);
			if (rd_val[0] === 1'b0) break;
		end
		if (n == 1000) timed_out();
	endtask
	task automatic read_status();
		frame(`FCWP_OP_READ_STATUS, 5'h08, 16'h0000);
		axi_rd(`FCWP_ADDR_RX);
	endtask
	task automatic wait_idle();
		int n;
		for (n = 0; n < 3000; n++) begin
			@(posedge clk);
			if (status_byte[0] === 1'b0) break;
		end
		if (n == 3000) timed_out();
		// One more edge so the decoded setup outputs follow the committed byte
		@(posedge clk);
	endtask
	task automatic wr_regs(input logic [4:0] bits, input logic [15:0] data);
		frame(`FCWP_OP_WRITE_UNLOCK, 5'h00, 16'h0000);
		frame(`FCWP_OP_WRITE_REGS, bits, data);
		wait_idle();
	endtask
	task automatic pe_try(input logic [9:0] blk, input logic [1:0] exp);
		@(posedge clk);
		pe_req <= 1'b1;
		pe_block <= blk;
		@(posedge clk);
		pe_req <= 1'b0;
		@(posedge clk);
		check({pe_refused, pe_granted}, exp);
	endtask
	// ==========================================
	// Main sequence
	initial begin
		repeat (16) @(posedge clk);
		resetn <= 1'b1;
		repeat (4) @(posedge clk);
		check({status_byte, setup_byte, hard_lock, soft_lock}, 18'h0001d);
		check({dummy_fast, dummy_dual, dummy_quad, drive_ohms}, 20'h8461e);
		axi_rd(`FCWP_ADDR_PIN);
		check(rd_val, 32'h1);
		axi_rd(8'h20);
		check({rsp, rd_val}, {`FCWP_RESP_SLVERR, 32'h0});
		axi_wr(8'h20, 32'h0);
		check(rsp, `FCWP_RESP_SLVERR);
		// Write without unlock, then a wrong-length write after unlock
		frame(`FCWP_OP_WRITE_REGS, 5'h08, 16'h8000);
		check(status_byte, 8'h00);
		frame(`FCWP_OP_WRITE_UNLOCK, 5'h00, 16'h0000);
		read_status();
		check(rd_val[7:0], 8'h02);
		frame(`FCWP_OP_WRITE_REGS, 5'h0c, 16'h8000);
		check(status_byte, 8'h02);
		// Two-byte write; status read while the cycle runs
		frame(`FCWP_OP_WRITE_REGS, 5'h10, 16'h076b);
		read_status();
		check(rd_val[1:0], 2'b11);
		wait_idle();
		check(status_byte, 8'h04);
		check(setup_byte, 8'h4b);
		check({dummy_fast, dummy_dual, dummy_quad, drive_ohms}, 20'h6642d);
		// Setup byte read back over the link
		frame(`FCWP_OP_READ_SETUP, 5'h08, 16'h0000);
		axi_rd(`FCWP_ADDR_RX);
		check(rd_val[7:0], 8'h4b);
		// Every drive and dummy code; origin written 0 must stay 1
		for (int i = 0; i < 8; i++) begin
			code = i[2:0];
			wr_regs(5'h10, {8'h04, code[1:0], 3'b000, code});
			check(setup_byte, {code[1:0], 3'b001, code});
			check({dummy_fast, dummy_dual, dummy_quad, drive_ohms},
				{fast_tab[code[1:0]], dual_tab[code[1:0]], quad_tab[code[1:0]], ohms_tab[code]});
		end
		frame(`FCWP_OP_ENTER_WIDE, 5'h00, 16'h0000);
		check(setup_byte[5], 1'b1);
		frame(`FCWP_OP_EXIT_WIDE, 5'h00, 16'h0000);
		check(setup_byte[5], 1'b0);
		// Level 1 from the bottom end protects block 0 only
		pe_try(10'h000, 2'b10);
		pe_try(10'h001, 2'b01);
		pe_try(10'h3ff, 2'b01);
		// Lock bit by a one-byte write leaves the setup byte alone
		wr_regs(5'h08, 16'h8400);
		check({status_byte, setup_byte}, 16'h84cf);
		check({hard_lock, soft_lock}, 2'b01);
		axi_wr(`FCWP_ADDR_PIN, 32'h0);
		repeat (8) @(posedge clk);
		check({hard_lock, soft_lock}, 2'b10);
		four_wire <= 1'b1;
		repeat (3) @(posedge clk);
		check({hard_lock, soft_lock}, 2'b01);
		four_wire <= 1'b0;
		wr_regs(5'h08, 16'h0000);
		check(status_byte, 8'h86);
		axi_wr(`FCWP_ADDR_PIN, 32'h1);
		repeat (8) @(posedge clk);
		check({hard_lock, soft_lock}, 2'b01);
		// Pin kept high through the locked write
		wr_regs(5'h08, 16'hc000);
		check(status_byte, 8'hc0);
		axi_wr(`FCWP_ADDR_PIN, 32'h0);
		repeat (8) @(posedge clk);
		check({hard_lock, soft_lock}, 2'b01);
		wr_regs(5'h08, 16'h0000);
		check(status_byte, 8'h00);
		close_out();
	end
	// Guard against a hang anywhere
	initial begin
		repeat (100000) @(posedge clk);
		timed_out();
	end
endmodule
